// ==== hw/pcu_consts.svh ====
// Constants of the performance counter unit: access codes, fields, counts.
// Assumes a single core clock and a 32-bit machine register width.
`ifndef PCU_CONSTS_SVH
`define PCU_CONSTS_SVH

// =====================================================================
// Widths and counts
`define PCU_XLEN 32
`define PCU_CNT_W 64
`define PCU_NUM_SLOTS 32
`define PCU_FIRST_EVT 3
`define PCU_SEL_W 4
`define PCU_NUM_EVENTS 15
`define PCU_SMODE_PRESENT 1'b1

// =====================================================================
// Field positions in the enable and stop masks
`define PCU_CYCLES_BIT 0
`define PCU_TIMER_BIT 1
`define PCU_RETIRED_BIT 2

// =====================================================================
// Access codes (12-bit); slot n sits at base + n
`define PCU_A_CNT_LO 12'hb00
`define PCU_A_CNT_HI 12'hb80
`define PCU_A_SEL 12'h320
`define PCU_A_STOP 12'h320
`define PCU_A_ENABLE 12'h306
`define PCU_A_VIEW_LO 12'hc00
`define PCU_A_VIEW_HI 12'hc80

// =====================================================================
// Reset values of the control state
`define PCU_RST_ENABLE 32'h0000_0000
`define PCU_RST_STOP 32'h0000_0000
`define PCU_RST_CNT 64'h0000_0000_0000_0000
`define PCU_RST_SEL 4'h0

`endif

// ==== hw/pcu_pkg.sv ====
// Types of the performance counter unit.
// Assumes pcu_consts.svh is on the include path.
`include "pcu_consts.svh"

package pcu_pkg;

    // =================================================================
    // Privilege levels as driven by the core
    typedef enum logic [1:0] {
        PCU_PRIV_USER = 2'h0,
        PCU_PRIV_SUPER = 2'h1,
        PCU_PRIV_RSVD = 2'h2,
        PCU_PRIV_MACHINE = 2'h3
    } pcu_priv_type;

    typedef logic [`PCU_CNT_W-1:0] pcu_cnt_type;
    typedef logic [`PCU_SEL_W-1:0] pcu_sel_type;

    // =================================================================
    // Whole state of the unit
    typedef struct packed {
        pcu_cnt_type [`PCU_NUM_SLOTS-1:0] cnt;
        pcu_sel_type [`PCU_NUM_SLOTS-1:0] sel;
        logic [`PCU_XLEN-1:0] enable;
        logic [`PCU_XLEN-1:0] stop;
        logic [`PCU_XLEN-1:0] rdata;
        logic illegal;
        logic ack;
    } pcu_state_type;

endpackage

// ==== hw/pcu_perf_counter_unit.sv ====
// Performance counter unit: cycle, retired and 29 event counters,
// lower-mode access enable and per-counter count stop mask.
// Assumes the core pipeline drives access requests, retire and event
// pulses and the platform timer value on the same clock.
//
// Overview of operation
// (R01) Cycle count adds one every core clock
// (R02) Retired count adds one per retire pulse
// (R03) Counters writable with any value
// (R04) Writes land after the access completes
// (R05) One shared cycle count for all threads
// (R06) Twenty-nine event counters follow their selector
// (R07) Selector zero never counts; illegal codes zero
// (R08) Every event counter and selector is implemented
// (R09) Low and high halves touch own bits
// (R10) Enable mask: cycles, timer, retired, events
// (R11) Enable mask never disturbs the counters
// (R12) Denied lower-mode view read is illegal
// (R13) Enabled view readable from next lower mode
// (R14) User views shadow counters and platform timer
// (R15) Timer halves return own 32 bits
// (R16) Enable mask present, fields legal only
// (R17) Stop mask affects counting, never access
// (R18) Stop bit set holds the counter
// (R19) Cycle stop bit shared by all threads
// (R20) Stop mask clear means always counting
// (R21) Platform timer cannot be stopped
// (R22) Counters wrap silently past maximum
`timescale 1ns/1ps

module pcu_perf_counter_unit (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic acc_req_in,
    input wire logic acc_write_in,
    input wire logic [11:0] acc_code_in,
    input wire logic [`PCU_XLEN-1:0] acc_wdata_in,
    input wire pcu_pkg::pcu_priv_type priv_in,
    input wire logic retire_in,
    input wire logic [`PCU_NUM_EVENTS:1] event_in,
    input wire logic [`PCU_CNT_W-1:0] timer_in,
    output logic [`PCU_XLEN-1:0] acc_rdata_out,
    output logic acc_illegal_out,
    output logic acc_ack_out
);
    import pcu_pkg::*;

    pcu_state_type state_r;
    pcu_state_type state_nxt;

    // =================================================================
    // Access decode
    logic [4:0] slot;
    logic [6:0] group;
    logic hit_lo;
    logic hit_hi;
    logic hit_sel;
    logic hit_stop;
    logic hit_enable;
    logic hit_view_lo;
    logic hit_view_hi;
    logic is_machine;
    logic view_allowed;
    logic bad;
    logic [`PCU_XLEN-1:0] rd;
    logic [`PCU_CNT_W-1:0] view_src;

    assign slot = acc_code_in[4:0];
    assign group = acc_code_in[11:5];
    assign hit_lo = (group == 7'(`PCU_A_CNT_LO >> 5)) && (slot != 5'h01);
    assign hit_hi = (group == 7'(`PCU_A_CNT_HI >> 5)) && (slot != 5'h01);
    assign hit_stop = (acc_code_in == `PCU_A_STOP);
    assign hit_sel = (group == 7'(`PCU_A_SEL >> 5)) && (slot >= 5'(`PCU_FIRST_EVT));
    assign hit_enable = (acc_code_in == `PCU_A_ENABLE);
    assign hit_view_lo = (group == 7'(`PCU_A_VIEW_LO >> 5));
    assign hit_view_hi = (group == 7'(`PCU_A_VIEW_HI >> 5));
    assign is_machine = (priv_in == PCU_PRIV_MACHINE);

    // Views: timer slot mirrors the platform timer, others the counters
    assign view_src = (slot == 5'(`PCU_TIMER_BIT)) ? timer_in : state_r.cnt[slot]; // [R14]

    // Machine always; the mode just below machine only with enable set;
    // user mode under a supervisor has no second-level enable here.
    always_comb begin
        view_allowed = 1'b0;
        if (is_machine) begin
            view_allowed = 1'b1;
        end else if (state_r.enable[slot]) begin // [R12] [R17]
            if (`PCU_SMODE_PRESENT) begin
                view_allowed = (priv_in == PCU_PRIV_SUPER); // [R13]
            end else begin
                view_allowed = (priv_in == PCU_PRIV_USER); // [R13]
            end
        end
    end

    // Read data and refusal
    always_comb begin
        rd = 32'h0000_0000;
        bad = 1'b0;
        if (hit_view_lo || hit_view_hi) begin
            if (!view_allowed || acc_write_in) begin
                bad = 1'b1; // [R12]
            end else if (hit_view_hi) begin
                rd = view_src[63:32]; // [R15]
            end else begin
                rd = view_src[31:0]; // [R15]
            end
        end else if (!is_machine) begin
            bad = 1'b1;
        end else if (hit_lo) begin
            rd = state_r.cnt[slot][31:0]; // [R09]
        end else if (hit_hi) begin
            rd = state_r.cnt[slot][63:32]; // [R09]
        end else if (hit_sel) begin
            rd = {28'h0000000, state_r.sel[slot]};
        end else if (hit_stop) begin
            rd = state_r.stop;
        end else if (hit_enable) begin
            rd = state_r.enable; // [R16]
        end else begin
            bad = 1'b1;
        end
    end

    // =================================================================
    // Next state
    logic [`PCU_NUM_SLOTS-1:0] bump;

    // Which counters see an increment this cycle
    always_comb begin
        bump = 32'h0000_0000;
        bump[`PCU_CYCLES_BIT] = 1'b1; // [R01]
        bump[`PCU_RETIRED_BIT] = retire_in; // [R02]
        for (int i = `PCU_FIRST_EVT; i < `PCU_NUM_SLOTS; i++) begin
            // Code zero and unused codes select nothing
            if (state_r.sel[i] != 4'h0) begin // [R07]
                bump[i] = event_in[state_r.sel[i]]; // [R06] [R08]
            end
        end
        // Timer slot is not a counter here, so it can never be held
        bump[`PCU_TIMER_BIT] = 1'b0; // [R21]
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = acc_req_in;
        state_nxt.illegal = acc_req_in && bad;
        state_nxt.rdata = acc_req_in ? rd : 32'h0000_0000;
        // Enable mask takes no part in counting
        for (int i = 0; i < `PCU_NUM_SLOTS; i++) begin
            if (bump[i] && !state_r.stop[i]) begin // [R11] [R18] [R20]
                state_nxt.cnt[i] = state_r.cnt[i] + 64'h1; // [R22]
            end
        end
        // Software write wins over the increment of the same cycle, so the
        // written half holds exactly the value written when the access completes.
        if (acc_req_in && acc_write_in && !bad) begin // [R04]
            if (hit_lo) begin
                state_nxt.cnt[slot][31:0] = acc_wdata_in; // [R03] [R09]
            end else if (hit_hi) begin
                state_nxt.cnt[slot][63:32] = acc_wdata_in; // [R03] [R09]
            end else if (hit_sel) begin
                // Codes above the event count are not legal; store zero
                if (acc_wdata_in <= 32'(`PCU_NUM_EVENTS)) begin // [R07]
                    state_nxt.sel[slot] = acc_wdata_in[3:0];
                end else begin
                    state_nxt.sel[slot] = 4'h0;
                end
            end else if (hit_stop) begin
                state_nxt.stop = acc_wdata_in; // [R17] [R19]
                state_nxt.stop[`PCU_TIMER_BIT] = 1'b0; // [R21]
            end else if (hit_enable) begin
                state_nxt.enable = acc_wdata_in; // [R10] [R16]
            end
        end
    end

    // =================================================================
    // State register; one copy serves every thread of the core
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r.cnt <= {`PCU_NUM_SLOTS{`PCU_RST_CNT}}; // [R05]
            state_r.sel <= {`PCU_NUM_SLOTS{`PCU_RST_SEL}};
            state_r.enable <= `PCU_RST_ENABLE;
            state_r.stop <= `PCU_RST_STOP;
            state_r.rdata <= 32'h0000_0000;
            state_r.illegal <= 1'b0;
            state_r.ack <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign acc_rdata_out = state_r.rdata;
    assign acc_illegal_out = state_r.illegal;
    assign acc_ack_out = state_r.ack;

endmodule

// ==== verification/pcu_core_model.sv ====
// Core pipeline stand-in: retire, event and timer sources.
// Assumes the bench steers it on the core clock.
`timescale 1ns/1ps
module pcu_core_model (
    input wire logic clk_in,
    input wire logic ret_in,
    input wire logic [15:1] lines_in,
    output logic retire_out = 1'b0,
    output logic [15:1] event_out = 15'h0,
    output logic [63:0] timer_out = 64'h0000_0000_ffff_fff0
);
    // ====
    // Timer steps oddly so both halves move; it never stops
    always @(posedge clk_in) begin
        retire_out <= ret_in;
        event_out <= lines_in;
        timer_out <= timer_out + 64'h0000_0001_0000_0003;
    end
endmodule

// ==== verification/pcu_checker.sv ====
// Checker of the counter unit access port.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module pcu_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic acc_req_in,
    input wire logic acc_write_in,
    input wire logic [11:0] acc_code_in,
    input wire pcu_pkg::pcu_priv_type priv_in,
    input wire logic [63:0] timer_in,
    input wire logic [31:0] acc_rdata_out,
    input wire logic acc_illegal_out,
    input wire logic acc_ack_out
);
    import pcu_pkg::*;
    logic [63:0] tq;
    logic mr;
    logic vw;
    assign mr = acc_req_in && !acc_write_in && priv_in == PCU_PRIV_MACHINE;
    assign vw = acc_req_in && acc_code_in[11:8] == 4'hc;
    always_ff @(posedge clk_in) begin
        tq <= timer_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ====
    // Handshake, refusal and timer view data
    property p_ack; acc_req_in |=> acc_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_idle; !acc_req_in |=> !acc_ack_out && acc_rdata_out == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_ill; acc_illegal_out |-> acc_ack_out && acc_rdata_out == 32'h0; endproperty
    a_ill: assert property (p_ill) else $error("refusal leaks data");
    property p_vw; vw && acc_write_in |=> acc_illegal_out; endproperty
    a_vw: assert property (p_vw) else $error("view write taken");
    property p_usr; vw && priv_in == PCU_PRIV_USER |=> acc_illegal_out; endproperty
    a_usr: assert property (p_usr) else $error("user view read");
    property p_low; acc_req_in && priv_in != PCU_PRIV_MACHINE
        && acc_code_in[11:8] == 4'hb |=> acc_illegal_out; endproperty
    a_low: assert property (p_low) else $error("low mode machine access");
    property p_mok; mr && acc_code_in inside {12'hb00, 12'h306, 12'hc00}
        |=> !acc_illegal_out; endproperty
    a_mok: assert property (p_mok) else $error("machine read refused");
    property p_tlo; mr && acc_code_in == 12'hc01 |=> acc_rdata_out == tq[31:0]; endproperty
    a_tlo: assert property (p_tlo) else $error("timer low wrong");
    property p_thi; mr && acc_code_in == 12'hc81 |=> acc_rdata_out == tq[63:32]; endproperty
    a_thi: assert property (p_thi) else $error("timer high wrong");
endmodule
bind pcu_perf_counter_unit pcu_checker pcu_checker_inst (
    .clk_in, .rst_in, .acc_req_in, .acc_write_in, .acc_code_in, .priv_in,
    .timer_in, .acc_rdata_out, .acc_illegal_out, .acc_ack_out
);

// ==== verification/pcu_perf_counter_unit_tb.sv ====
// Bench of the counter unit: access sequences with expected values.
// Assumes the core model drives retire, event and timer inputs.
`timescale 1ns/1ps
module pcu_perf_counter_unit_tb;
    import pcu_pkg::*;
    localparam pcu_priv_type M = PCU_PRIV_MACHINE;
    localparam pcu_priv_type S = PCU_PRIV_SUPER;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic acc_req_in = 1'b0;
    logic acc_write_in = 1'b0;
    logic [11:0] acc_code_in = 12'h0;
    logic [31:0] acc_wdata_in = 32'h0;
    pcu_priv_type priv_in = M;
    logic ret = 1'b0;
    logic [15:1] lines = 15'h0;
    logic [15:1] ln;
    logic retire_in;
    logic [15:1] event_in;
    logic [63:0] timer_in;
    logic [31:0] acc_rdata_out;
    logic acc_illegal_out;
    logic acc_ack_out;
    logic [31:0] rd;
    logic [31:0] c0;
    logic [63:0] tv;
    logic il;
    int n_errors = 0;
    int checks_done = 0;
    always #50 clk_in = ~clk_in;
    pcu_perf_counter_unit pcu_perf_counter_unit_inst (
        .clk_in, .rst_in, .acc_req_in, .acc_write_in, .acc_code_in, .acc_wdata_in,
        .priv_in, .retire_in, .event_in, .timer_in, .acc_rdata_out,
        .acc_illegal_out, .acc_ack_out
    );
    pcu_core_model pcu_core_model_inst (
        .clk_in, .ret_in(ret), .lines_in(lines), .retire_out(retire_in),
        .event_out(event_in), .timer_out(timer_in)
    );
    // ====
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic go(input logic w, input logic [11:0] c, input logic [31:0] d = 32'h0,
            input pcu_priv_type p = M);
        @(posedge clk_in);
        acc_req_in <= 1'b1;
        acc_write_in <= w;
        acc_code_in <= c;
        acc_wdata_in <= d;
        priv_in <= p;
        // Timer value that the taking edge will sample
        @(negedge clk_in);
        tv = timer_in;
        @(posedge clk_in);
        acc_req_in <= 1'b0;
        #1;
        rd = acc_rdata_out;
        il = acc_illegal_out;
        chk("ack", 32'h1, {31'h0, acc_ack_out});
    endtask
    task automatic burst(input logic r, input logic [15:1] l, input int n);
        repeat (n) begin
            @(posedge clk_in);
            ret <= r;
            lines <= l;
        end
        @(posedge clk_in);
        ret <= 1'b0;
        lines <= 15'h0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ====
    // Tests
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        go(0, 12'h306);
        chk("enable", 32'h0, rd);
        go(0, 12'h320);
        chk("stop", 32'h0, rd);
        go(1, 12'hb02, 32'h5);
        go(1, 12'hb82, 32'h12);
        burst(1'b1, 15'h0, 10);
        go(0, 12'hb02);
        chk("ret_lo", 32'hf, rd);
        go(0, 12'hb82);
        chk("ret_hi", 32'h12, rd);
        go(1, 12'hb02, 32'hffff_ffff);
        go(1, 12'hb82, 32'hffff_ffff);
        burst(1'b1, 15'h0, 1);
        go(0, 12'hb02);
        chk("wrap_lo", 32'h0, rd);
        go(0, 12'hb82);
        chk("wrap_hi", 32'h0, rd);
        $display("test retired done");
        for (int k = 1; k <= 15; k++) begin
            ln = 15'h1 << (k - 1);
            go(1, 12'hb03, 32'h0);
            go(1, 12'h323, k);
            burst(1'b0, ln, 3);
            burst(1'b0, ~ln, 2);
            go(0, 12'hb03);
            chk("evt3", 32'h3, rd);
            go(0, 12'hb04);
            chk("evt4", 32'h0, rd);
        end
        go(1, 12'h324, 32'h10);
        go(0, 12'h324);
        chk("sel_bad", 32'h0, rd);
        go(1, 12'h324, 32'h7);
        go(0, 12'h324);
        chk("sel", 32'h7, rd);
        $display("test events done");
        go(1, 12'h320, 32'hf);
        go(0, 12'h320);
        chk("stop", 32'hd, rd);
        go(0, 12'hb00);
        c0 = rd;
        go(0, 12'hb00);
        chk("cyc_held", c0, rd);
        go(0, 12'hb02);
        c0 = rd;
        burst(1'b1, 15'h4000, 3);
        go(0, 12'hb02);
        chk("ret_held", c0, rd);
        go(0, 12'hb03);
        chk("evt_held", 32'h3, rd);
        go(1, 12'h320, 32'h0);
        go(0, 12'hb00);
        c0 = rd;
        go(0, 12'hb00);
        chk("cyc", c0 + 32'h2, rd);
        $display("test stop done");
        go(0, 12'hc00, , S);
        chk("deny", 32'h1, {31'h0, il});
        go(1, 12'h306, 32'h5);
        go(1, 12'h320, 32'h1);
        go(0, 12'hc00, , S);
        chk("allow", 32'h0, {31'h0, il});
        go(0, 12'hc02, , S);
        chk("allow_ret", 32'h0, {31'h0, il});
        go(0, 12'hc03, , S);
        chk("deny_evt", 32'h1, {31'h0, il});
        go(0, 12'hc00, , PCU_PRIV_USER);
        chk("user", 32'h1, {31'h0, il});
        go(1, 12'hc00, 32'h1);
        chk("view_wr", 32'h1, {31'h0, il});
        go(0, 12'h7ff);
        chk("unmapped", 32'h1, {31'h0, il});
        go(0, 12'hc01);
        chk("timer_lo", tv[31:0], rd);
        go(0, 12'hc81);
        chk("timer_hi", tv[63:32], rd);
        chk("timer_ok", 32'h0, {31'h0, il});
        $display("test access done");
        summarize();
    end
    initial begin
        #1_000_000;
        n_errors++;
        summarize();
    end
endmodule
